//--- verilog/btsf_top.sv
/*
  Block-transfer status flags, upper bits: fifo read request and host
  byte read flags, reserved bits, enables and the slave buffer
  interrupt request. Assumes an APB master and host events on mclk.
*/
// How it works
// R1 - Software keeps the three reserved status bits 7 to 5 at zero.
// R2 - A host write into a full FIFO sets the fifo read request flag.
// R3 - Fifo flag plus common and fifo enables request the interrupt.
// R4 - Firmware drains the FIFO before clearing the fifo flag.
// R5 - A flag clears only on a zero write after reading it as one.
// R6 - Each host byte read sets the host byte read flag in bit 3.
// R7 - Host flag plus common and host enables request the interrupt.
// R8 - Writing one to a flag bit leaves it unchanged.
// R9 - Flags reset to zero, hold until cleared, and set beats clear.
`default_nettype none
module btsf_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host events
  input wire btsf_pkg::btsf_event_t host_evt,
  // Interrupt request
  output logic slave_buffer_irq
);
  import btsf_pkg::*;

  // ************************************************************
  // Bus decode
  // ************************************************************
  logic acc, first_acc, rd_acc, wr_acc, hit_status, hit_enable;
  logic fifo_flag, host_flag;
  logic [2:0] rsvd_reg, rsvd_next;
  logic [2:0] en_reg, en_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic irq_reg, irq_next;
  logic pready_reg, pready_next;

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // One wait state: the first access cycle builds the answer in
  // flops, the second shows it with pready high. Read data and
  // flag arming share one edge, so firmware is never armed on a
  // value it did not see.
  assign acc = psel && penable;
  assign first_acc = acc && !pready_reg;
  assign rd_acc = first_acc && !pwrite;
  // Writes land only at the completing edge
  assign wr_acc = acc && pready_reg && pwrite;
  assign hit_status = addr_is(paddr, BTSF_STATUS_OFS);
  assign hit_enable = addr_is(paddr, BTSF_ENABLE_OFS);

  // ************************************************************
  // Flags
  // ************************************************************
  btsf_flag u_fifo_flag (
    .mclk(mclk),
    .rst(rst),
    .set_evt(host_evt.fifo_full_write), // R2
    .rd_strobe(rd_acc && hit_status),
    .wr_strobe(wr_acc && hit_status), // R4
    .wr_bit(pwdata[BTSF_FIFO_REQ_BIT]), // R8
    .flag(fifo_flag)
  );

  btsf_flag u_host_flag (
    .mclk(mclk),
    .rst(rst),
    .set_evt(host_evt.host_byte_read), // R6
    .rd_strobe(rd_acc && hit_status),
    .wr_strobe(wr_acc && hit_status),
    .wr_bit(pwdata[BTSF_HOST_RD_BIT]), // R8
    .flag(host_flag)
  );

  // ************************************************************
  // Registers and read data
  // ************************************************************
  always_comb begin
    rsvd_next = rsvd_reg;
    en_next = en_reg;
    prdata_next = BTSF_RDATA_RST;
    pslverr_next = 1'b0;
    pready_next = first_acc;
    // Answer built in the first access cycle
    if (first_acc) begin
      if (hit_status) begin
        pslverr_next = 1'b0;
      end else if (hit_enable) begin
        pslverr_next = 1'b0;
      end else begin
        pslverr_next = 1'b1;
      end
    end
    if (wr_acc) begin
      if (hit_status) begin
        // Plain storage, no function
        rsvd_next = pwdata[BTSF_RSVD_HI:BTSF_RSVD_LO]; // R1
      end else if (hit_enable) begin
        en_next = pwdata[2:0] & BTSF_EN_MASK;
      end
    end
    if (rd_acc) begin
      if (hit_status) begin
        prdata_next[BTSF_RSVD_HI:BTSF_RSVD_LO] = rsvd_reg;
        prdata_next[BTSF_FIFO_REQ_BIT] = fifo_flag;
        prdata_next[BTSF_HOST_RD_BIT] = host_flag;
      end else if (hit_enable) begin
        prdata_next[2:0] = en_reg;
      end
    end
    irq_next = en_reg[BTSF_EN_COMMON_BIT] &&
      ((fifo_flag && en_reg[BTSF_EN_FIFO_BIT]) || // R3
       (host_flag && en_reg[BTSF_EN_HOST_BIT])); // R7
  end

  // Read data and pslverr stand only in the completing cycle,
  // together with pready, then return to zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsvd_reg <= BTSF_RESET_8[2:0];
      en_reg <= BTSF_RESET_8[2:0];
      prdata_reg <= BTSF_RDATA_RST;
      pslverr_reg <= 1'b0;
      irq_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      rsvd_reg <= rsvd_next;
      en_reg <= en_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      irq_reg <= irq_next;
      pready_reg <= pready_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign slave_buffer_irq = irq_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_fifo_armed;
    fifo_flag && en_reg[BTSF_EN_COMMON_BIT] && en_reg[BTSF_EN_FIFO_BIT];
  endsequence

  sequence s_host_armed;
    host_flag && en_reg[BTSF_EN_COMMON_BIT] && en_reg[BTSF_EN_HOST_BIT];
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wait;
    psel && penable && !pready;
  endsequence

  sequence s_status_read;
    psel && penable && !pwrite && !pready && hit_status;
  endsequence

  // Interrupt request
  AST_FIFO_IRQ: assert property (@(posedge mclk) // R3
    disable iff (rst) s_fifo_armed |=> slave_buffer_irq)
    else $error("fifo request did not raise the interrupt");
  AST_HOST_IRQ: assert property (@(posedge mclk) // R7
    disable iff (rst) s_host_armed |=> slave_buffer_irq)
    else $error("host read did not raise the interrupt");
  AST_NO_COMMON: assert property (@(posedge mclk) // R3
    disable iff (rst) !en_reg[BTSF_EN_COMMON_BIT] |=> !slave_buffer_irq)
    else $error("interrupt without common enable");
  AST_IRQ_QUIET: assert property (@(posedge mclk) // R7
    disable iff (rst) !(fifo_flag && en_reg[BTSF_EN_FIFO_BIT]) &&
      !(host_flag && en_reg[BTSF_EN_HOST_BIT]) |=> !slave_buffer_irq)
    else $error("interrupt without an enabled source");

  // Flag setting
  AST_FIFO_SET: assert property (@(posedge mclk) // R2
    disable iff (rst) host_evt.fifo_full_write |=> fifo_flag)
    else $error("fifo full write did not set the flag");
  AST_HOST_SET: assert property (@(posedge mclk) // R6
    disable iff (rst) host_evt.host_byte_read |=> host_flag)
    else $error("host byte read did not set the flag");

  // Read data and reserved storage
  AST_RD_STATUS: assert property (@(posedge mclk) // R5
    disable iff (rst) s_status_read |=>
      prdata[BTSF_FIFO_REQ_BIT] == $past(fifo_flag))
    else $error("status read data wrong");
  AST_RD_HOST: assert property (@(posedge mclk) // R6
    disable iff (rst) s_status_read |=>
      prdata[BTSF_HOST_RD_BIT] == $past(host_flag))
    else $error("host flag read data wrong");
  AST_RSVD_KEEP: assert property (@(posedge mclk) // R1
    disable iff (rst) (wr_acc && hit_status &&
      pwdata[BTSF_RSVD_HI:BTSF_RSVD_LO] == 3'h0) |=> rsvd_reg == 3'h0)
    else $error("reserved bits not kept at zero");

  // Bus handshake: setup, one wait cycle, then completion
  AST_WAIT_STATE: assert property (@(posedge mclk) // R5
    disable iff (rst) s_setup ##1 s_wait |=> pready)
    else $error("access did not complete after one wait cycle");
  AST_READY_PULSE: assert property (@(posedge mclk) // R5
    disable iff (rst) pready |=> !pready)
    else $error("pready stood longer than one cycle");
  AST_ERR_WITH_READY: assert property (@(posedge mclk) // R5
    disable iff (rst) pslverr |-> pready)
    else $error("pslverr shown without pready");
endmodule
`default_nettype wire

//--- verilog/btsf_pkg.sv
/*
  Package for the block-transfer status flag bank: register offsets,
  field positions, reset values and the event carrier struct.
  Assumes a 32-bit APB master and one 10 MHz clock.
*/
`default_nettype none
package btsf_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] BTSF_STATUS_OFS = 8'h00;
  localparam logic [7:0] BTSF_ENABLE_OFS = 8'h04;
  localparam logic [7:0] BTSF_RESET_8 = 8'h00;
  localparam logic [31:0] BTSF_RDATA_RST = 32'h0000_0000;
  // ************************************************************
  // Status field positions
  // ************************************************************
  localparam int BTSF_FIFO_REQ_BIT = 4;
  localparam int BTSF_HOST_RD_BIT = 3;
  localparam int BTSF_RSVD_LO = 5;
  localparam int BTSF_RSVD_HI = 7;
  // ************************************************************
  // Enable field positions
  // ************************************************************
  localparam int BTSF_EN_COMMON_BIT = 0;
  localparam int BTSF_EN_FIFO_BIT = 1;
  localparam int BTSF_EN_HOST_BIT = 2;
  localparam logic [2:0] BTSF_EN_MASK = 3'h7;
  // Host side events, one-cycle pulses
  typedef struct packed {
    logic fifo_full_write;
    logic host_byte_read;
  } btsf_event_t;
endpackage
`default_nettype wire

//--- verilog/btsf_flag.sv
/*
  One sticky status flag with read-armed clear.
  Assumes set pulses and bus strobes are on mclk.
*/
`default_nettype none
module btsf_flag (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Events
  input wire logic set_evt,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic wr_bit,
  // State
  output logic flag
);
  logic flag_reg, flag_next;
  logic armed_reg, armed_next;

  always_comb begin
    flag_next = flag_reg;
    armed_next = armed_reg;
    if (rd_strobe) begin
      armed_next = flag_reg;
    end
    if (wr_strobe) begin
      if (!wr_bit && armed_reg) begin
        flag_next = 1'b0; // R5
      end
      armed_next = 1'b0;
    end
    // Set wins over clear
    if (set_evt) begin
      flag_next = 1'b1; // R9
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_reg <= 1'b0; // R9
      armed_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      armed_reg <= armed_next;
    end
  end

  assign flag = flag_reg;

  AST_CLEAR_NEEDS_READ: assert property (@(posedge mclk) // R5
    disable iff (rst) (flag_reg && !armed_reg && !set_evt) |=> flag_reg)
    else $error("flag cleared without a prior read of one");
  AST_WRITE_ONE_KEEPS: assert property (@(posedge mclk) // R8
    disable iff (rst) (flag_reg && wr_strobe && wr_bit) |=> flag_reg)
    else $error("write of one changed the flag");
  AST_SET_WINS: assert property (@(posedge mclk) // R9
    disable iff (rst) set_evt |=> flag_reg)
    else $error("set event lost");
endmodule
`default_nettype wire

//--- tb/btsf_host_model.sv
/*
  Host side model: host byte reads and writes into a small FIFO.
  Assumes the bench pulses wr, rd and drain for one mclk cycle.
*/
`default_nettype none
module btsf_host_model #(parameter int DEPTH = 4) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Commands
  input wire logic wr,
  input wire logic rd,
  input wire logic drain,
  // Events
  output var btsf_pkg::btsf_event_t evt
);
  timeunit 1ns;
  timeprecision 1ns;
  import btsf_pkg::*;
  // ****************
  // Host behaviour
  // ****************
  int cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      evt <= '0;
    end else begin
      evt.fifo_full_write <= wr && cnt == DEPTH;
      evt.host_byte_read <= rd;
      if (drain) cnt <= 0;
      else if (wr && cnt < DEPTH) cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/bt_slave_status_flags_upper_tb_top.sv
/*
  Bench for the status flag bank: APB master, reference model, host.
  Assumes the slave may add wait states; data is taken at the pready edge.
*/
`default_nettype none
module bt_slave_status_flags_upper_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import btsf_pkg::*;
  // ****************
  // Signals
  // ****************
  logic mclk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic hw = 0;
  logic hr = 0;
  logic dr = 0;
  btsf_event_t evt;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [7:0] es = '0;
  logic [7:0] arm = '0;
  logic [2:0] en = '0;
  btsf_top DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_evt(evt),
    .slave_buffer_irq(irq));
  btsf_host_model HOST (.mclk(mclk), .rst(rst), .wr(hw), .rd(hr),
    .drain(dr), .evt(evt));
  initial forever #50 mclk = ~mclk;
  // ****************
  // Tasks
  // ****************
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic err);
    logic [31:0] q;
    logic e;
    apb(0, a, '0, q, e);
    chk_bit(e, err);
    if (a == BTSF_STATUS_OFS) chk_word(q, {24'h0, es});
    if (a == BTSF_ENABLE_OFS) chk_word(q, {29'h0, en});
    if (a == BTSF_STATUS_OFS) arm = es & 8'h18;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1, a, {24'h0, d}, q, e);
    chk_bit(e, a != BTSF_STATUS_OFS && a != BTSF_ENABLE_OFS);
    if (a == BTSF_ENABLE_OFS) en = d[2:0];
    if (a == BTSF_STATUS_OFS) begin
      es = (es & ~(arm & ~d) & 8'h18) | (d & 8'he0);
      arm = '0;
    end
  endtask
  task automatic host(input int k);
    @(posedge mclk);
    hr <= k == 0;
    hw <= k == 1;
    dr <= k == 2;
    @(posedge mclk);
    hr <= 0;
    hw <= 0;
    dr <= 0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic sweep();
    for (int i = 0; i < 8; i++) begin
      wr(BTSF_ENABLE_OFS, i[7:0]);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk_bit(irq, en[0] & (en[1] & es[4] | en[2] & es[3]));
    end
  endtask
  // ****************
  // Sequence
  // ****************
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    logic [31:0] v;
    v = $urandom(79);
    v = $urandom;
    repeat (4) @(posedge mclk);
    rst <= 0;
    rd(BTSF_STATUS_OFS, 0);
    rd(BTSF_ENABLE_OFS, 0);
    rd(8'h08, 1);
    wr(8'h0c, v[15:8]);
    wr(BTSF_STATUS_OFS, (v[7:0] & 8'h1f) | 8'h18);
    rd(BTSF_STATUS_OFS, 0);
    host(0);
    es[3] = 1'b1;
    wr(BTSF_STATUS_OFS, es & 8'he0);
    rd(BTSF_STATUS_OFS, 0);
    wr(BTSF_STATUS_OFS, 8'h18);
    rd(BTSF_STATUS_OFS, 0);
    sweep();
    wr(BTSF_STATUS_OFS, es & 8'he0);
    rd(BTSF_STATUS_OFS, 0);
    for (int i = 0; i < 5; i++) begin
      host(1);
      es[4] = i == 4;
      rd(BTSF_STATUS_OFS, 0);
    end
    sweep();
    host(2);
    rd(BTSF_STATUS_OFS, 0);
    wr(BTSF_STATUS_OFS, 8'h00);
    rd(BTSF_STATUS_OFS, 0);
    finish_test();
  end
endmodule
`default_nettype wire
